/* File: inc/mipu_pkg.sv */
// Function
// - Fifteen sources, each with own pending flag, enable and vector address.
// - Software-set pending flag with enable raises a request like hardware.
// - One priority bit per source in priority registers; all reset low.
// - High request preempts low routine; nothing preempts a high routine.
// - Simultaneous requests: higher level first, fixed source order within a level.
// - Pending flags sampled and priority decoded every clock cycle.
// - Fastest response is five cycles: one detect plus four call cycles.
// - Request pending at return: one more instruction runs before the call.
// - Worst response without nesting is eighteen cycles: 1+5+8+4.
// - Equal or lower request waits for return and one following instruction.
// - Edge external source: pending flag cleared when CPU vectors to it.
// - Level external source: pending flag follows active input polarity.
package mipu_pkg;
  localparam int unsigned NUM_SRC        = 15;
  localparam int unsigned SRC_IDX_W      = 4;
  localparam logic [7:0]  ADDR_EN_MAIN   = 8'ha8;
  localparam logic [7:0]  ADDR_PRI_MAIN  = 8'hb8;
  localparam logic [7:0]  ADDR_EN_EXT1   = 8'he6;
  localparam logic [7:0]  ADDR_EN_EXT2   = 8'he7;
  localparam logic [7:0]  ADDR_PRI_EXT1  = 8'hf3;
  localparam logic [7:0]  ADDR_PRI_EXT2  = 8'hf4;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int unsigned GLOBAL_EN_BIT  = 7;
  localparam int unsigned EXT0_SRC       = 0;
  localparam int unsigned EXT1_SRC       = 2;
  localparam logic [15:0] VEC_BASE       = 16'h0003;
  localparam logic [15:0] VEC_STRIDE     = 16'h0008;
  localparam int unsigned DETECT_CYC     = 1;
  localparam int unsigned CALL_CYC       = 4;
  localparam int unsigned MIN_RESP_CYC   = DETECT_CYC + CALL_CYC;
  localparam int unsigned RET_CYC        = 5;
  localparam int unsigned DIV_CYC        = 8;
  localparam int unsigned MAX_RESP_CYC   = DETECT_CYC + RET_CYC + DIV_CYC + CALL_CYC;
  localparam logic [2:0]  CALL_CNT_LAST  = 3'(CALL_CYC - 1);
  typedef enum logic [1:0] {
    MIPU_IDLE = 2'b00,
    MIPU_CALL = 2'b01,
    MIPU_HOLD = 2'b10
  } mipu_state_type;
endpackage

/* File: rtl/mipu_ctrl.sv */
module mipu_ctrl #(
  parameter int unsigned NSRC = mipu_pkg::NUM_SRC
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_we,
  input  wire logic              sfr_re,
  output logic      [7:0]        sfr_rdata,
  output logic                   sfr_hit,
  input  wire logic [NSRC-1:0]   hw_set,
  input  wire logic [NSRC-1:0]   hw_clear,
  input  wire logic [NSRC-1:0]   sw_set,
  input  wire logic [NSRC-1:0]   sw_clear,
  input  wire logic              external_request_zero,
  input  wire logic              external_request_one,
  input  wire logic              ext0_edge_mode,
  input  wire logic              ext1_edge_mode,
  input  wire logic              ext0_polarity_bit,
  input  wire logic              ext1_polarity_bit,
  input  wire logic              insn_boundary,
  input  wire logic              return_from_interrupt,
  output logic      [NSRC-1:0]   pending_r,
  output logic                   long_call_req,
  output logic      [15:0]       vector_addr_r,
  output logic      [3:0]        vector_src_r,
  output logic                   vector_taken,
  output logic                   in_service_low_r,
  output logic                   in_service_high_r
);
  typedef logic [NSRC-1:0] mipu_vec_type;
  mipu_pkg::mipu_state_type state_r;
  logic [7:0] en_main_r, en_ext1_r, en_ext2_r, pri_main_r, pri_ext1_r, pri_ext2_r;
  logic [2:0] call_cnt_r;
  logic       ret_hold_r;
  logic       ext0_in_r, ext1_in_r;
  mipu_vec_type enable_v, pri_v, req_v, req_hi, req_lo, clr_v;
  logic       any_hi, any_lo, grant;
  logic [3:0] win_src;
  logic       win_hi;

  // Lowest index wins within a level
  function automatic logic [3:0] first_set(input mipu_vec_type v);
    first_set = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] s);
    vec_of = mipu_pkg::VEC_BASE + 16'(s) * mipu_pkg::VEC_STRIDE;
  endfunction

  assign enable_v = mipu_vec_type'({en_ext2_r[6:0], en_ext1_r, en_main_r[6:0]}) &
                    {NSRC{en_main_r[mipu_pkg::GLOBAL_EN_BIT]}};
  assign pri_v    = mipu_vec_type'({pri_ext2_r[6:0], pri_ext1_r, pri_main_r[6:0]});
  assign req_v    = pending_r & enable_v;
  assign req_hi   = req_v & pri_v;
  assign req_lo   = req_v & ~pri_v;
  assign any_hi   = |req_hi;
  assign any_lo   = |req_lo;
  // High preempts low only; nothing preempts high
  always_comb begin
    win_hi = any_hi;
    win_src = any_hi ? first_set(req_hi) : first_set(req_lo);
    grant = insn_boundary && !ret_hold_r && state_r == mipu_pkg::MIPU_IDLE &&
            !in_service_high_r &&
            (any_hi || (any_lo && !in_service_low_r));
  end
  assign long_call_req = state_r == mipu_pkg::MIPU_CALL;
  assign vector_taken  = grant;

  always_ff @(posedge clock) begin
    if (reset) begin
      en_main_r <= mipu_pkg::REG_RESET;
      en_ext1_r <= mipu_pkg::REG_RESET;
      en_ext2_r <= mipu_pkg::REG_RESET;
      pri_main_r <= mipu_pkg::REG_RESET;
      pri_ext1_r <= mipu_pkg::REG_RESET;
      pri_ext2_r <= mipu_pkg::REG_RESET;
    end else if (sfr_we) begin
      if (sfr_addr == mipu_pkg::ADDR_EN_MAIN) begin
        en_main_r <= sfr_wdata;
      end else if (sfr_addr == mipu_pkg::ADDR_EN_EXT1) begin
        en_ext1_r <= sfr_wdata;
      end else if (sfr_addr == mipu_pkg::ADDR_EN_EXT2) begin
        en_ext2_r <= sfr_wdata;
      end else if (sfr_addr == mipu_pkg::ADDR_PRI_MAIN) begin
        pri_main_r <= sfr_wdata;
      end else if (sfr_addr == mipu_pkg::ADDR_PRI_EXT1) begin
        pri_ext1_r <= sfr_wdata;
      end else if (sfr_addr == mipu_pkg::ADDR_PRI_EXT2) begin
        pri_ext2_r <= sfr_wdata;
      end
    end
  end

  always_comb begin
    sfr_hit = 1'b1;
    sfr_rdata = 8'h00;
    if (sfr_addr == mipu_pkg::ADDR_EN_MAIN) begin
      sfr_rdata = en_main_r;
    end else if (sfr_addr == mipu_pkg::ADDR_EN_EXT1) begin
      sfr_rdata = en_ext1_r;
    end else if (sfr_addr == mipu_pkg::ADDR_EN_EXT2) begin
      sfr_rdata = en_ext2_r;
    end else if (sfr_addr == mipu_pkg::ADDR_PRI_MAIN) begin
      sfr_rdata = pri_main_r;
    end else if (sfr_addr == mipu_pkg::ADDR_PRI_EXT1) begin
      sfr_rdata = pri_ext1_r;
    end else if (sfr_addr == mipu_pkg::ADDR_PRI_EXT2) begin
      sfr_rdata = pri_ext2_r;
    end else begin
      sfr_hit = 1'b0;
    end
    if (!sfr_re) begin
      sfr_rdata = 8'h00;
    end
  end

  // Edge detect on external inputs after polarity
  always_ff @(posedge clock) begin
    if (reset) begin
      ext0_in_r <= 1'b0;
      ext1_in_r <= 1'b0;
    end else begin
      ext0_in_r <= external_request_zero ~^ ext0_polarity_bit;
      ext1_in_r <= external_request_one ~^ ext1_polarity_bit;
    end
  end

  always_comb begin
    clr_v = hw_clear | sw_clear;
    if (grant && ((win_src == 4'(mipu_pkg::EXT0_SRC) && ext0_edge_mode) ||
                  (win_src == 4'(mipu_pkg::EXT1_SRC) && ext1_edge_mode))) begin
      clr_v[win_src] = 1'b1;
    end
  end

  // Set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      pending_r <= '0;
    end else begin
      pending_r <= (pending_r & ~clr_v) | hw_set | sw_set;
      if (ext0_edge_mode) begin
        if ((external_request_zero ~^ ext0_polarity_bit) && !ext0_in_r) begin
          pending_r[mipu_pkg::EXT0_SRC] <= 1'b1;
        end
      end else begin
        pending_r[mipu_pkg::EXT0_SRC] <= external_request_zero ~^ ext0_polarity_bit;
      end
      if (ext1_edge_mode) begin
        if ((external_request_one ~^ ext1_polarity_bit) && !ext1_in_r) begin
          pending_r[mipu_pkg::EXT1_SRC] <= 1'b1;
        end
      end else begin
        pending_r[mipu_pkg::EXT1_SRC] <= external_request_one ~^ ext1_polarity_bit;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= mipu_pkg::MIPU_IDLE;
      call_cnt_r <= 3'h0;
      vector_addr_r <= 16'h0000;
      vector_src_r <= 4'h0;
    end else begin
      case (state_r)
        mipu_pkg::MIPU_IDLE: begin
          if (grant) begin
            state_r <= mipu_pkg::MIPU_CALL;
            call_cnt_r <= 3'h0;
            vector_addr_r <= vec_of(win_src);
            vector_src_r <= win_src;
          end
        end
        mipu_pkg::MIPU_CALL: begin
          call_cnt_r <= call_cnt_r + 3'h1;
          if (call_cnt_r == mipu_pkg::CALL_CNT_LAST) begin
            state_r <= mipu_pkg::MIPU_IDLE;
          end
        end
        default: begin
          state_r <= mipu_pkg::MIPU_IDLE;
        end
      endcase
    end
  end

  // Marker per level; return clears the highest active one
  always_ff @(posedge clock) begin
    if (reset) begin
      in_service_low_r <= 1'b0;
      in_service_high_r <= 1'b0;
    end else if (grant) begin
      if (win_hi) begin
        in_service_high_r <= 1'b1;
      end else begin
        in_service_low_r <= 1'b1;
      end
    end else if (return_from_interrupt) begin
      if (in_service_high_r) begin
        in_service_high_r <= 1'b0;
      end else begin
        in_service_low_r <= 1'b0;
      end
    end
  end

  // After a return, one more instruction runs before a call
  always_ff @(posedge clock) begin
    if (reset) begin
      ret_hold_r <= 1'b0;
    end else if (return_from_interrupt) begin
      ret_hold_r <= 1'b1;
    end else if (insn_boundary) begin
      ret_hold_r <= 1'b0;
    end
  end

  property p_call_len;
    @(posedge clock) disable iff (reset)
      grant |=> long_call_req [*4] ##1 !long_call_req;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call not four cycles");

  property p_no_preempt_high;
    @(posedge clock) disable iff (reset) in_service_high_r |-> !grant;
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high preempted");

  property p_hi_first;
    @(posedge clock) disable iff (reset)
      grant && any_hi |-> req_hi[win_src] &&
        (req_hi & ((mipu_vec_type'(1) << win_src) - mipu_vec_type'(1))) == '0;
  endproperty
  a_hi_first: assert property (p_hi_first) else $error("low chosen over high");

  property p_ret_hold;
    @(posedge clock) disable iff (reset) return_from_interrupt |=> !grant;
  endproperty
  a_ret_hold: assert property (p_ret_hold) else $error("vector right after return");

  property p_equal_wait;
    @(posedge clock) disable iff (reset)
      in_service_low_r && !any_hi |-> !grant;
  endproperty
  a_equal_wait: assert property (p_equal_wait) else $error("equal level preempted");

  property p_vector;
    @(posedge clock) disable iff (reset)
      grant |=> vector_addr_r == vec_of(vector_src_r) && in_service_low_r | in_service_high_r;
  endproperty
  a_vector: assert property (p_vector) else $error("vector or marker wrong");

  property p_edge_clear;
    @(posedge clock) disable iff (reset)
      grant && ext0_edge_mode && win_src == 4'h0 && !hw_set[0] && !sw_set[0] &&
      !((external_request_zero ~^ ext0_polarity_bit) && !ext0_in_r) |=> !pending_r[0];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");

  property p_level_follow;
    @(posedge clock) disable iff (reset)
      !ext1_edge_mode |=> pending_r[2] == $past(external_request_one ~^ ext1_polarity_bit);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag wrong");

  property p_sw_req;
    @(posedge clock) disable iff (reset)
      sw_set[1] && enable_v[1] |=> req_v[1];
  endproperty
  a_sw_req: assert property (p_sw_req) else $error("software request lost");

  c_hi_preempt: cover property (@(posedge clock) disable iff (reset)
    in_service_low_r && grant && win_hi);
  c_ret_then_call: cover property (@(posedge clock) disable iff (reset)
    return_from_interrupt ##[1:20] grant);
  c_two_same: cover property (@(posedge clock) disable iff (reset)
    grant && $countones(req_lo) > 1);
endmodule

/* File: verif/mipu_cpu_model.sv */
module mipu_cpu_model (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic long_call_req,
  input  wire logic ret_cmd,
  input  wire logic slow,
  output logic      insn_boundary,
  output logic      return_from_interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] len_r;
  // No instruction ends from the second call cycle to one cycle after the call, or in the cycle a return completes
  always_ff @(posedge clock) begin
    if (reset) begin
      len_r                 <= 3'h0;
      insn_boundary         <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      len_r                 <= len_r + 3'h1;
      return_from_interrupt <= ret_cmd;
      insn_boundary         <= !ret_cmd && !long_call_req && (!slow || len_r == 3'h7);
    end
  end
endmodule

/* File: verif/mipu_ctrl_bench.sv */
module mipu_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] reg_addrs [6] = '{mipu_pkg::ADDR_EN_MAIN, mipu_pkg::ADDR_PRI_MAIN,
    mipu_pkg::ADDR_EN_EXT1, mipu_pkg::ADDR_EN_EXT2, mipu_pkg::ADDR_PRI_EXT1, mipu_pkg::ADDR_PRI_EXT2};
  logic        clock, reset, sfr_we, sfr_re, sfr_hit, vector_taken, long_call_req, ret_cmd;
  logic        external_request_zero, external_request_one, ext0_edge_mode, ext1_edge_mode;
  logic        ext0_polarity_bit, ext1_polarity_bit, insn_boundary, return_from_interrupt;
  logic        in_service_low_r, in_service_high_r, slow, pol;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic [14:0] hw_set, hw_clear, sw_set, sw_clear, pending_r, ma, mb;
  logic [15:0] vector_addr_r;
  logic [3:0]  vector_src_r;
  int          error_cnt, checks, seed, lat, a, b, s;

  mipu_ctrl #(.NSRC(mipu_pkg::NUM_SRC)) u_dut (.clock, .reset, .sfr_addr, .sfr_wdata, .sfr_we,
    .sfr_re, .sfr_rdata, .sfr_hit, .hw_set, .hw_clear, .sw_set, .sw_clear, .external_request_zero,
    .external_request_one, .ext0_edge_mode, .ext1_edge_mode, .ext0_polarity_bit,
    .ext1_polarity_bit, .insn_boundary, .return_from_interrupt, .pending_r, .long_call_req,
    .vector_addr_r, .vector_src_r, .vector_taken, .in_service_low_r, .in_service_high_r);
  mipu_cpu_model u_cpu (.clock, .reset, .long_call_req, .ret_cmd, .slow, .insn_boundary,
    .return_from_interrupt);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic reg_wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= ad;
    sfr_wdata <= d;
    sfr_we    <= 1'b1;
    @(posedge clock);
    sfr_we    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] ad, input logic [7:0] exp, input logic hit);
    @(posedge clock);
    sfr_addr <= ad;
    sfr_re   <= 1'b1;
    #1;
    chk_word({8'h0, sfr_rdata}, {8'h0, exp}, "read data");
    chk_bit(sfr_hit, hit, "register hit");
    @(posedge clock);
    sfr_re   <= 1'b0;
  endtask

  // Global enable rides on bit 7 of the main enable register
  task automatic set_masks(input logic [14:0] en, input logic [14:0] pri, input logic glob);
    reg_wr(mipu_pkg::ADDR_EN_MAIN, {glob, en[6:0]});
    reg_wr(mipu_pkg::ADDR_EN_EXT1, en[14:7]);
    reg_wr(mipu_pkg::ADDR_PRI_MAIN, {1'b0, pri[6:0]});
    reg_wr(mipu_pkg::ADDR_PRI_EXT1, pri[14:7]);
  endtask

  task automatic flags(input logic [14:0] ss, sc, hs, hc);
    @(posedge clock);
    sw_set   <= ss;
    sw_clear <= sc;
    hw_set   <= hs;
    hw_clear <= hc;
    @(posedge clock);
    {sw_set, sw_clear, hw_set, hw_clear} <= '0;
  endtask

  task automatic do_ret;
    @(posedge clock);
    ret_cmd <= 1'b1;
    @(posedge clock);
    ret_cmd <= 1'b0;
  endtask

  task automatic no_grant(input int cyc);
    for (int i = 0; i < cyc; i++) begin
      @(posedge clock);
      #1;
      chk_bit(vector_taken, 1'b0, "unexpected grant");
    end
  endtask

  task automatic ext_drive(input int e, input logic pin, input logic mode, input logic pl);
    @(posedge clock);
    if (e == 0) begin
      external_request_zero <= pin;
      ext0_edge_mode        <= mode;
      ext0_polarity_bit     <= pl;
    end else begin
      external_request_one  <= pin;
      ext1_edge_mode        <= mode;
      ext1_polarity_bit     <= pl;
    end
  endtask

  task automatic wait_grant(input logic [3:0] src, input logic high);
    int n;
    lat = 0;
    #1;
    while (vector_taken !== 1'b1 && lat < 60) begin
      @(posedge clock);
      #1;
      lat++;
    end
    if (vector_taken !== 1'b1) begin
      chk_bit(1'b0, 1'b1, "grant timeout");
      close_out;
    end
    @(posedge clock);
    #1;
    chk_word(vector_addr_r, mipu_pkg::VEC_BASE + mipu_pkg::VEC_STRIDE * src, "vector");
    chk_word({12'h0, vector_src_r}, {12'h0, src}, "source");
    chk_bit(high ? in_service_high_r : in_service_low_r, 1'b1, "marker set");
    n = 0;
    while (long_call_req === 1'b1 && n < 9) begin
      n++;
      @(posedge clock);
      #1;
    end
    chk_word(16'(n), 16'(mipu_pkg::CALL_CYC), "call length");
  endtask

  initial begin
    seed      = 32'h242e;
    error_cnt = 0;
    checks    = 0;
    reset     = 1'b1;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    {sfr_we, sfr_re, ret_cmd, slow, external_request_zero, external_request_one} = '0;
    // Edge mode, so software can set the external sources' flags
    {ext0_edge_mode, ext1_edge_mode, ext0_polarity_bit, ext1_polarity_bit} = 4'hf;
    {hw_set, hw_clear, sw_set, sw_clear} = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    reg_wr(8'ha9, 8'hff);
    for (int i = 0; i < 6; i++) reg_rd(reg_addrs[i], mipu_pkg::REG_RESET, 1'b1);
    reg_rd(8'ha9, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      s = $random(seed);
      reg_wr(reg_addrs[i], s[7:0]);
      reg_rd(reg_addrs[i], s[7:0], 1'b1);
    end
    $display("test registers done");
    for (int k = 0; k < 15; k++) begin
      pol = 1'($random(seed));
      ma  = 15'h1 << k;
      set_masks(ma, pol ? ma : 15'h0, 1'b1);
      flags(ma, 0, 0, 0);
      wait_grant(k[3:0], pol);
      chk_word(16'(lat), 16'h0, "detect latency");
      flags(0, ma, 0, 0);
      do_ret;
      no_grant(3);
      chk_bit(pol ? in_service_high_r : in_service_low_r, 1'b0, "marker clear");
    end
    $display("test sources done");
    a  = $unsigned($random(seed)) % 14;
    b  = a + 1 + $unsigned($random(seed)) % (14 - a);
    ma = 15'h1 << a;
    mb = 15'h1 << b;
    set_masks(ma | mb, mb, 1'b1);
    flags(ma | mb, 0, 0, 0);
    wait_grant(b[3:0], 1'b1);
    flags(0, mb, 0, 0);
    no_grant(10);
    do_ret;
    wait_grant(a[3:0], 1'b0);
    chk_word(16'(lat), 16'h2, "grant after return");
    flags(mb, 0, 0, 0);
    wait_grant(b[3:0], 1'b1);
    chk_bit(in_service_low_r, 1'b1, "low marker kept");
    flags(0, mb, 0, 0);
    do_ret;
    no_grant(10);
    chk_bit(in_service_high_r, 1'b0, "high marker");
    chk_bit(in_service_low_r, 1'b1, "low marker");
    flags(0, ma, 0, 0);
    do_ret;
    set_masks(ma | mb, 0, 1'b1);
    flags(ma | mb, 0, 0, 0);
    wait_grant(a[3:0], 1'b0);
    flags(0, ma | mb, 0, 0);
    do_ret;
    $display("test priority done");
    set_masks(ma, 0, 1'b0);
    flags(0, 0, ma, 0);
    no_grant(5);
    chk_bit(pending_r[a], 1'b1, "hardware set");
    flags(0, 0, 0, ma);
    no_grant(1);
    chk_bit(pending_r[a], 1'b0, "hardware clear");
    $display("test hardware flags done");
    @(posedge clock);
    slow <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      s   = e ? mipu_pkg::EXT1_SRC : mipu_pkg::EXT0_SRC;
      pol = 1'($random(seed));
      set_masks(15'h1 << s, 0, 1'b1);
      ext_drive(e, pol, 1'b0, pol);
      wait_grant(s[3:0], 1'b0);
      chk_bit(pending_r[s], 1'b1, "level flag");
      ext_drive(e, !pol, 1'b0, pol);
      no_grant(3);
      chk_bit(pending_r[s], 1'b0, "level flag drop");
      do_ret;
      ext_drive(e, pol, 1'b1, pol);
      wait_grant(s[3:0], 1'b0);
      chk_bit(pending_r[s], 1'b0, "edge flag cleared");
      do_ret;
      ext_drive(e, !pol, 1'b1, pol);
    end
    $display("test external done");
    close_out;
  end
endmodule
